//--- src/ocblp_defines.svh
// offsets, field positions, reset values for the control/bulk list pointer bank
`ifndef OCBLP_DEFINES_SVH
`define OCBLP_DEFINES_SVH

`define OCBLP_OFS_CTRL_CUR  8'h24
`define OCBLP_OFS_BULK_HEAD 8'h28
`define OCBLP_OFS_BULK_CUR  8'h2c
`define OCBLP_ADDR_MSB      31
`define OCBLP_ADDR_LSB      4
`define OCBLP_RSVD_MASK     32'hffff_fff0
`define OCBLP_PTR_RESET     32'h0000_0000

`endif

//--- src/ocblp_pkg.sv
// types for the control/bulk list pointer bank
`default_nettype none
package ocblp_pkg;
  typedef logic [31:0] ocblp_word_t;
  typedef enum logic [1:0] {
    OCBLP_SEL_NONE      = 2'h0,
    OCBLP_SEL_CTRL_CUR  = 2'h1,
    OCBLP_SEL_BULK_HEAD = 2'h3,
    OCBLP_SEL_BULK_CUR  = 2'h2
  } ocblp_sel_t;
endpackage
`default_nettype wire

//--- src/ocblp_list_pointers.sv
// control current, bulk head and bulk current list pointer registers
`timescale 1ns/10ps
`default_nettype none
`include "ocblp_defines.svh"

// Summary of operation
// - the control current pointer is read at offset 0x24 of the controller memory window.
// - the control current pointer holds a descriptor address in bits 31..4, bits 3..0 read zero.
// - after a control descriptor is served the pointer advances to the next and is kept across frames.
// - at the end of the control list a set filled flag reloads the pointer from the head and is cleared.
// - the control current pointer resets to zero and zero marks the end of the control list.
// - the bulk head pointer is a read/write register at 0x28, address in bits 31..4, reset zero.
// - bulk traversal starts at the bulk head pointer.
// - during initialisation the bulk head pointer is loaded from the communication area.
// - the bulk current pointer is a read/write register at 0x2c resetting to zero.
// - the bulk list is served round robin in insertion order.
// - at the end of the bulk list a set filled flag reloads the pointer from the head and is cleared.
// - the bulk current pointer resets to zero and zero marks the end of the bulk list.

module ocblp_list_pointers (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // register access from the memory window
  input  wire logic [7:0]  reg_offset_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_hit_o,
  // controller state from the command/control registers
  input  wire logic        control_list_enable_i,
  input  wire logic        bulk_list_enable_bit_i,
  input  wire logic [31:0] control_list_head_pointer_i,
  // list engine events
  input  wire logic        ctrl_advance_i,
  input  wire logic [31:0] ctrl_next_ed_i,
  input  wire logic        ctrl_list_end_i,
  input  wire logic        bulk_advance_i,
  input  wire logic [31:0] bulk_next_ed_i,
  input  wire logic        bulk_list_end_i,
  input  wire logic        hcca_init_i,
  input  wire logic [31:0] hcca_bulk_head_i,
  // list filled flags from the command/status register
  input  wire logic        control_list_filled_flag_i,
  input  wire logic        bulk_list_filled_flag_i,
  output logic             clear_control_filled_o,
  output logic             clear_bulk_filled_o,
  // pointer state toward the list engine
  output logic      [31:0] control_current_address_field_o,
  output logic      [31:0] bulk_head_address_field_o,
  output logic      [31:0] bulk_current_address_field_o,
  output logic             ctrl_list_empty_o,
  output logic             bulk_list_empty_o
);

  // ==========================================================
  // helpers
  // low four bits are reserved and never stored
  function automatic ocblp_pkg::ocblp_word_t ptr_clean(input ocblp_pkg::ocblp_word_t v);
    ptr_clean = v & `OCBLP_RSVD_MASK;
  endfunction

  function automatic ocblp_pkg::ocblp_sel_t decode(input logic [7:0] ofs);
    if (ofs == `OCBLP_OFS_CTRL_CUR) begin
      decode = ocblp_pkg::OCBLP_SEL_CTRL_CUR;
    end else if (ofs == `OCBLP_OFS_BULK_HEAD) begin
      decode = ocblp_pkg::OCBLP_SEL_BULK_HEAD;
    end else if (ofs == `OCBLP_OFS_BULK_CUR) begin
      decode = ocblp_pkg::OCBLP_SEL_BULK_CUR;
    end else begin
      decode = ocblp_pkg::OCBLP_SEL_NONE;
    end
  endfunction

  // write qualifier: strobe, matching offset, and not locked by a list enable
  function automatic logic sw_write(
    input logic                  wr,
    input ocblp_pkg::ocblp_sel_t got,
    input ocblp_pkg::ocblp_sel_t want,
    input logic                  locked
  );
    if (!wr) begin
      sw_write = 1'b0;
    end else if (got != want) begin
      sw_write = 1'b0;
    end else begin
      sw_write = !locked;
    end
  endfunction

  // a zero address field marks the end of a list
  function automatic logic ptr_is_end(input ocblp_pkg::ocblp_word_t v);
    ptr_is_end = (v[`OCBLP_ADDR_MSB:`OCBLP_ADDR_LSB] == 28'h000_0000);
  endfunction

  // register view on the read port
  function automatic ocblp_pkg::ocblp_word_t reg_view(
    input ocblp_pkg::ocblp_sel_t  s,
    input ocblp_pkg::ocblp_word_t ctrl_cur,
    input ocblp_pkg::ocblp_word_t bulk_head,
    input ocblp_pkg::ocblp_word_t bulk_cur
  );
    if (s == ocblp_pkg::OCBLP_SEL_CTRL_CUR) begin
      reg_view = ctrl_cur;
    end else if (s == ocblp_pkg::OCBLP_SEL_BULK_HEAD) begin
      reg_view = bulk_head;
    end else if (s == ocblp_pkg::OCBLP_SEL_BULK_CUR) begin
      reg_view = bulk_cur;
    end else begin
      reg_view = 32'h0000_0000;
    end
  endfunction

  // ==========================================================
  // register decode
  ocblp_pkg::ocblp_sel_t  sel;
  logic                   wr_ctrl_cur;
  logic                   wr_bulk_head;
  logic                   wr_bulk_cur;
  logic                   ctrl_wrap;
  logic                   bulk_wrap;

  // an unmapped offset decodes to none: writes drop, reads give zero with no hit
  assign sel = decode(reg_offset_i);

  always_comb begin
    // a refused write falls through to the engine events
    wr_ctrl_cur  = sw_write(reg_wr_i, sel, ocblp_pkg::OCBLP_SEL_CTRL_CUR, control_list_enable_i);
    wr_bulk_head = sw_write(reg_wr_i, sel, ocblp_pkg::OCBLP_SEL_BULK_HEAD, 1'b0);
    wr_bulk_cur  = sw_write(reg_wr_i, sel, ocblp_pkg::OCBLP_SEL_BULK_CUR, bulk_list_enable_bit_i);
    ctrl_wrap    = ctrl_list_end_i && control_list_filled_flag_i;
    bulk_wrap    = bulk_list_end_i && bulk_list_filled_flag_i;
  end

  // ==========================================================
  // control current pointer
  // moved by the engine; software loads it only while the control list is off
  ocblp_pkg::ocblp_word_t ctrl_cur_ff;
  ocblp_pkg::ocblp_word_t nxt_ctrl_cur;
  logic                   clr_ctrl_ff;
  logic                   nxt_clr_ctrl;

  always_comb begin
    nxt_ctrl_cur = ctrl_cur_ff;
    nxt_clr_ctrl = 1'b0;
    // software write first, then list end, then advance
    if (wr_ctrl_cur) begin
      nxt_ctrl_cur = ptr_clean(reg_wdata_i);
    end else if (ctrl_list_end_i) begin
      if (ctrl_wrap) begin
        nxt_ctrl_cur = ptr_clean(control_list_head_pointer_i);
        nxt_clr_ctrl = 1'b1;
      end
    end else if (ctrl_advance_i) begin
      nxt_ctrl_cur = ptr_clean(ctrl_next_ed_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_cur_ff <= `OCBLP_PTR_RESET;
      clr_ctrl_ff <= 1'b0;
    end else begin
      ctrl_cur_ff <= nxt_ctrl_cur;
      clr_ctrl_ff <= nxt_clr_ctrl;
    end
  end

  // ==========================================================
  // bulk head pointer
  // traversal restarts here on every bulk wrap
  ocblp_pkg::ocblp_word_t bulk_head_ff;
  ocblp_pkg::ocblp_word_t nxt_bulk_head;

  always_comb begin
    nxt_bulk_head = bulk_head_ff;
    // the init load beats a same-cycle software write
    if (hcca_init_i) begin
      nxt_bulk_head = ptr_clean(hcca_bulk_head_i);
    end else if (wr_bulk_head) begin
      nxt_bulk_head = ptr_clean(reg_wdata_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bulk_head_ff <= `OCBLP_PTR_RESET;
    end else begin
      bulk_head_ff <= nxt_bulk_head;
    end
  end

  // ==========================================================
  // bulk current pointer
  // moved by the engine; software loads it only while the bulk list is off
  ocblp_pkg::ocblp_word_t bulk_cur_ff;
  ocblp_pkg::ocblp_word_t nxt_bulk_cur;
  logic                   clr_bulk_ff;
  logic                   nxt_clr_bulk;

  always_comb begin
    nxt_bulk_cur = bulk_cur_ff;
    nxt_clr_bulk = 1'b0;
    // the wrap copies the stored head, not a head written in the same cycle
    if (wr_bulk_cur) begin
      nxt_bulk_cur = ptr_clean(reg_wdata_i);
    end else if (bulk_list_end_i) begin
      if (bulk_wrap) begin
        nxt_bulk_cur = bulk_head_ff;
        nxt_clr_bulk = 1'b1;
      end
    end else if (bulk_advance_i) begin
      nxt_bulk_cur = ptr_clean(bulk_next_ed_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bulk_cur_ff <= `OCBLP_PTR_RESET;
      clr_bulk_ff <= 1'b0;
    end else begin
      bulk_cur_ff <= nxt_bulk_cur;
      clr_bulk_ff <= nxt_clr_bulk;
    end
  end

  // ==========================================================
  // end-of-list flags
  logic                   ctrl_empty_ff;
  logic                   bulk_empty_ff;
  logic                   nxt_ctrl_empty;
  logic                   nxt_bulk_empty;

  always_comb begin
    // follow the next pointer values so flag and pointer move together
    nxt_ctrl_empty = ptr_is_end(nxt_ctrl_cur);
    nxt_bulk_empty = ptr_is_end(nxt_bulk_cur);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_empty_ff <= 1'b1;
      bulk_empty_ff <= 1'b1;
    end else begin
      ctrl_empty_ff <= nxt_ctrl_empty;
      bulk_empty_ff <= nxt_bulk_empty;
    end
  end

  // ==========================================================
  // read data
  ocblp_pkg::ocblp_word_t rdata_ff;
  ocblp_pkg::ocblp_word_t nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    // zero whenever no read is taken, so stale data never stands
    if (reg_rd_i) begin
      nxt_rdata = reg_view(sel, ctrl_cur_ff, bulk_head_ff, bulk_cur_ff);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // read hit
  logic                   hit_ff;
  logic                   nxt_hit;

  always_comb begin
    // only a mapped offset answers with a hit
    nxt_hit = reg_rd_i && (sel != ocblp_pkg::OCBLP_SEL_NONE);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_o                     = rdata_ff;
  assign reg_hit_o                       = hit_ff;
  assign clear_control_filled_o          = clr_ctrl_ff;
  assign clear_bulk_filled_o             = clr_bulk_ff;
  assign control_current_address_field_o = ctrl_cur_ff;
  assign bulk_head_address_field_o       = bulk_head_ff;
  assign bulk_current_address_field_o    = bulk_cur_ff;
  assign ctrl_list_empty_o               = ctrl_empty_ff;
  assign bulk_list_empty_o               = bulk_empty_ff;

endmodule
`default_nettype wire

//--- dv/ocblp_sva.sv
// assertions on the list pointer bank ports
`timescale 1ns/10ps
`default_nettype none
`include "ocblp_defines.svh"
module ocblp_sva (
  input wire logic        core_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_hit_o, ctrl_advance_i, ctrl_list_end_i,
  input wire logic        control_list_enable_i, bulk_list_end_i, hcca_init_i, clear_control_filled_o,
  input wire logic        control_list_filled_flag_i, bulk_list_filled_flag_i, clear_bulk_filled_o,
  input wire logic        ctrl_list_empty_o, bulk_list_empty_o, bulk_list_enable_bit_i,
  input wire logic [7:0]  reg_offset_i,
  input wire logic [31:0] reg_rdata_o, control_list_head_pointer_i, ctrl_next_ed_i, hcca_bulk_head_i,
  input wire logic [31:0] control_current_address_field_o, bulk_head_address_field_o, bulk_current_address_field_o
);
  localparam logic [31:0] M = `OCBLP_RSVD_MASK;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic        cw, bw;
  logic [31:0] cc, bh, bc;
  assign {cc, bh, bc} = {control_current_address_field_o, bulk_head_address_field_o, bulk_current_address_field_o};
  // allowed software writes that override engine updates
  assign cw = reg_wr_i && reg_offset_i == `OCBLP_OFS_CTRL_CUR && !control_list_enable_i;
  assign bw = reg_wr_i && reg_offset_i == `OCBLP_OFS_BULK_CUR && !bulk_list_enable_bit_i;
  property p_rd; reg_rd_i && reg_offset_i == `OCBLP_OFS_CTRL_CUR |=> reg_hit_o && reg_rdata_o == $past(cc); endproperty
  a_rd: assert property (p_rd) else $error("control pointer read wrong");
  property p_rsvd; ((cc | bh | bc | reg_rdata_o) & 32'h0000_000f) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("low bits not zero");
  property p_cadv; ctrl_advance_i && !ctrl_list_end_i && !cw |=> cc == ($past(ctrl_next_ed_i) & M); endproperty
  a_cadv: assert property (p_cadv) else $error("control advance wrong");
  property p_cwrap; ctrl_list_end_i && control_list_filled_flag_i && !cw
    |=> clear_control_filled_o && cc == ($past(control_list_head_pointer_i) & M); endproperty
  a_cwrap: assert property (p_cwrap) else $error("control wrap wrong");
  property p_clock; reg_wr_i && reg_offset_i == `OCBLP_OFS_CTRL_CUR && control_list_enable_i
    && !ctrl_advance_i && !ctrl_list_end_i |=> $stable(cc); endproperty
  a_clock: assert property (p_clock) else $error("blocked write changed pointer");
  property p_empty; ctrl_list_empty_o == (cc == 32'h0) && bulk_list_empty_o == (bc == 32'h0); endproperty
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  property p_bwrap; bulk_list_end_i && bulk_list_filled_flag_i && !bw |=> clear_bulk_filled_o && bc == $past(bh); endproperty
  a_bwrap: assert property (p_bwrap) else $error("bulk wrap wrong");
  property p_hcca; hcca_init_i |=> bh == ($past(hcca_bulk_head_i) & M); endproperty
  a_hcca: assert property (p_hcca) else $error("bulk head load wrong");
endmodule
bind ocblp_list_pointers ocblp_sva u_sva (.*);
`default_nettype wire

//--- dv/ocblp_host_model.sv
// host driver model: word writes and reads over the memory window
`timescale 1ns/10ps
`default_nettype none
module ocblp_host_model (
  input  wire logic        core_clk_i, ctrl_lock_i, bulk_lock_i, hit_i,
  input  wire logic [31:0] rdata_i,
  output logic      [7:0]  ofs_o,
  output logic             wr_o, rd_o,
  output logic      [31:0] wd_o
);
  initial {ofs_o, wr_o, rd_o, wd_o} = '0;
  // r forces a write the driver must not make
  task automatic wr(input logic [7:0] o, input logic [31:0] d, input logic r);
    if (r || !((o == 8'h24 && ctrl_lock_i) || (o == 8'h2c && bulk_lock_i))) begin
      @(posedge core_clk_i) #1;
      ofs_o = o;
      wd_o = d;
      wr_o = 1'b1;
      @(posedge core_clk_i) #1;
      wr_o = 1'b0;
      wd_o = ~d;
    end
  endtask
  task automatic rd(input logic [7:0] o, output logic [31:0] d, output logic h);
    @(posedge core_clk_i) #1;
    ofs_o = o;
    rd_o = 1'b1;
    @(posedge core_clk_i) #1;
    rd_o = 1'b0;
    d = rdata_i;
    h = hit_i;
  endtask
endmodule
`default_nettype wire

//--- dv/ocblp_list_pointers_tb.sv
// self-checking bench for the list pointer bank
`timescale 1ns/10ps
`default_nettype none
module ocblp_list_pointers_tb;
  typedef struct { logic [7:0] o; logic [31:0] w, e; logic h; } ocblp_row_t;
  ocblp_row_t  rows [4] = '{'{8'h24, 32'hdead_beef, 32'hdead_bee0, 1'b1}, '{8'h28, 32'h1234_567f, 32'h1234_5670, 1'b1},
                            '{8'h2c, 32'hffff_ffff, 32'hffff_fff0, 1'b1}, '{8'h30, 32'h0bad_cafe, 32'h0, 1'b0}};
  logic        clk = 1'b0, rst = 1'b1, wr, rd, hit, h;
  logic [1:0]  en = 2'h0, fl = 2'h0;
  wire  [1:0]  clr, emp;
  logic [4:0]  ev = 5'h0;
  logic [7:0]  ofs;
  logic [31:0] wd, rdata, cc, bh, bc, d;
  int          bad_count = 0, num_checks = 0;
  initial forever #50 clk = ~clk;
  ocblp_host_model host (.core_clk_i(clk), .ctrl_lock_i(en[0]), .bulk_lock_i(en[1]), .hit_i(hit), .rdata_i(rdata),
    .ofs_o(ofs), .wr_o(wr), .rd_o(rd), .wd_o(wd));
  ocblp_list_pointers dut (.core_clk_i(clk), .rst_i(rst), .reg_offset_i(ofs), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_hit_o(hit), .control_list_enable_i(en[0]),
    .bulk_list_enable_bit_i(en[1]), .control_list_head_pointer_i(32'h5555_5558), .ctrl_advance_i(ev[0]),
    .ctrl_next_ed_i(32'habcd_ef1f), .ctrl_list_end_i(ev[1]), .bulk_advance_i(ev[2]), .bulk_next_ed_i(32'h0246_8ace),
    .bulk_list_end_i(ev[3]), .hcca_init_i(ev[4]), .hcca_bulk_head_i(32'h1357_9bdf),
    .control_list_filled_flag_i(fl[0]), .bulk_list_filled_flag_i(fl[1]), .clear_control_filled_o(clr[0]),
    .clear_bulk_filled_o(clr[1]), .control_current_address_field_o(cc), .bulk_head_address_field_o(bh),
    .bulk_current_address_field_o(bc), .ctrl_list_empty_o(emp[0]), .bulk_list_empty_o(emp[1]));
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic step;
    @(posedge clk) #1;
  endtask
  task automatic summarize;
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) step;
    rst = 1'b0;
    foreach (rows[i]) begin
      host.wr(rows[i].o, rows[i].w, 1'b0);
      host.rd(rows[i].o, d, h);
      chk({63'h0, h, d}, {63'h0, rows[i].h, rows[i].e});
    end
    en = 2'h3;
    host.wr(8'h24, 32'h0, 1'b1);
    host.wr(8'h2c, 32'h0, 1'b1);
    chk({cc, bc, 32'h0}, {32'hdead_bee0, 32'hffff_fff0, 32'h0});
    ev = 5'h05;
    step;
    chk({cc, bc, 32'h0}, {32'habcd_ef10, 32'h0246_8ac0, 32'h0});
    ev = 5'h0a;
    fl = 2'h3;
    step;
    chk({cc, bc, 30'h0, clr}, {32'h5555_5550, 32'h1234_5670, 32'h3});
    ev = 5'h1a;
    fl = 2'h0;
    step;
    chk({cc, bh, 30'h0, clr}, {32'h5555_5550, 32'h1357_9bd0, 32'h0});
    ev = 5'h0;
    rst = 1'b1;
    step;
    rst = 1'b0;
    chk({cc | bh | bc, 30'h0, emp, 32'h0}, {32'h0, 32'h3, 32'h0});
    summarize;
  end
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
